// >>> src/cid_decoder.sv
// Cylinder input command decoder, top level.
// Assumes asynchronous command pins and end stop levels from the motion layer on mclk.
`timescale 1ns/1ps
`include "cid_defines.svh"
module cid_decoder #(
  parameter int FILTER_CYC = `CID_FILTER_CYC
) (
  input  wire logic                   mclk,                     // Clock, 50 MHz
  input  wire logic                   rst,                      // Sync reset
  input  wire logic [`CID_ADDR_W-1:0] address,                  // Avalon address
  input  wire logic                   read,                     // Avalon read
  input  wire logic                   write,                    // Avalon write
  input  wire logic [31:0]            writedata,                // Avalon write data
  output logic      [31:0]            readdata,                 // Avalon read data
  output logic                        waitrequest,              // Avalon stall
  output logic                        irq,                      // Interrupt level
  input  wire logic                   extend_request_input,     // Extend pin
  input  wire logic                   retract_request_input,    // Retract pin
  input  wire logic                   teach_reset_input,        // Teach pin
  input  wire logic                   at_outer_end,             // Outer stop reached
  input  wire logic                   at_inner_end,             // Inner stop reached
  output logic                        drive_out,                // Move outward
  output logic                        drive_in,                 // Move inward
  output logic                        slow_speed,               // Teach speed
  output logic                        hold_position,            // Brake, hold in loop
  output logic                        powerless,                // Control off
  output logic                        error_ack,                // Error acknowledge pulse
  output logic                        teach_start,              // Teach run start pulse
  output logic                        stroke_record,            // Stroke taught pulse
  output logic                        forbidden_combo,          // Undefined inputs
  output logic                        outer_endstop_indicator,  // Extended indicator
  output logic                        inner_endstop_indicator   // Retracted indicator
);
  localparam int CW = $clog2(FILTER_CYC + 1);

  logic [2:0]          in_s;
  logic [2:0]          cand;
  logic [2:0]          filt;
  logic [CW-1:0]       cnt;
  logic [2:0]          next_cand;
  logic [2:0]          next_filt;
  logic [CW-1:0]       next_cnt;
  cid_pkg::cid_mode_e  mode_cfg;
  cid_pkg::cid_mode_e  mode_act;
  cid_pkg::cid_mode_e  next_mode_act;
  cid_pkg::cid_cmd_e   cmd;
  cid_pkg::cid_cmd_e   cmd_q;
  cid_pkg::cid_state_e state;
  cid_pkg::cid_state_e next_state;
  logic                first_in;
  logic                next_first_in;
  logic                reached;
  logic                next_drive_out;
  logic                next_drive_in;
  logic                next_slow;
  logic                next_hold;
  logic                next_powerless;
  logic                next_ack;
  logic                next_teach;
  logic                next_stroke;
  logic                next_forbid;
  logic                new_cmd;

  // ********************************************************
  // Input synchronisation and stability filter
  // ********************************************************
  cid_sync #(
    .W (3)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({teach_reset_input, retract_request_input, extend_request_input}),
    .dout (in_s)
  );

  always_comb begin
    next_cand = cand;
    next_cnt  = cnt;
    next_filt = filt;
    // Combination must stand unchanged before it is decoded
    if (in_s != cand) begin
      next_cand = in_s;
      next_cnt  = '0;
    end else if (cnt < CW'(FILTER_CYC - 1)) begin
      next_cnt = cnt + CW'(1);
    end else begin
      next_filt = cand;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cand <= 3'h0;
      cnt  <= '0;
      filt <= 3'h0;
    end else begin
      cand <= next_cand;
      cnt  <= next_cnt;
      filt <= next_filt;
    end
  end

  // ********************************************************
  // Command decode per variant
  // ********************************************************
  always_comb begin
    cmd = cid_pkg::CID_CMD_HOLD;
    case (mode_act)
      cid_pkg::CID_MODE_REST_IN: begin
        case ({filt[`CID_IN_TCH], filt[`CID_IN_EXT]})
          2'h0:    cmd = cid_pkg::CID_CMD_IN;
          2'h1:    cmd = cid_pkg::CID_CMD_OUT;
          2'h2:    cmd = cid_pkg::CID_CMD_TEACH_IN;
          default: cmd = cid_pkg::CID_CMD_UNDEF;
        endcase
      end
      cid_pkg::CID_MODE_REST_OUT: begin
        case ({filt[`CID_IN_TCH], filt[`CID_IN_RET]})
          2'h0:    cmd = cid_pkg::CID_CMD_OUT;
          2'h1:    cmd = cid_pkg::CID_CMD_IN;
          2'h2:    cmd = cid_pkg::CID_CMD_TEACH_OUT;
          default: cmd = cid_pkg::CID_CMD_UNDEF;
        endcase
      end
      default: begin
        case (filt)
          3'h0:    cmd = cid_pkg::CID_CMD_HOLD;
          3'h1:    cmd = cid_pkg::CID_CMD_OUT;
          3'h2:    cmd = cid_pkg::CID_CMD_IN;
          3'h6:    cmd = cid_pkg::CID_CMD_TEACH_IN;
          3'h5:    cmd = cid_pkg::CID_CMD_TEACH_OUT;
          3'h4:    cmd = cid_pkg::CID_CMD_POWERLESS;
          default: cmd = cid_pkg::CID_CMD_UNDEF;
        endcase
      end
    endcase
  end

  // ********************************************************
  // Run and teach sequencing
  // ********************************************************
  assign new_cmd = (cmd != cmd_q);
  assign reached = first_in ^ (state == cid_pkg::CID_ST_TEACH_B) ? at_inner_end : at_outer_end;

  always_comb begin
    next_state     = state;
    next_first_in  = first_in;
    next_mode_act  = mode_act;
    next_ack       = 1'b0;
    next_teach     = 1'b0;
    next_stroke    = 1'b0;
    next_drive_out = 1'b0;
    next_drive_in  = 1'b0;
    next_slow      = 1'b0;
    next_hold      = 1'b0;
    next_powerless = 1'b0;
    next_forbid    = (cmd == cid_pkg::CID_CMD_UNDEF);
    case (state)
      cid_pkg::CID_ST_RUN: begin
        // Variant changes only at rest with all inputs low
        if (filt == 3'h0) begin
          next_mode_act = mode_cfg;
        end
        if (new_cmd && cmd == cid_pkg::CID_CMD_TEACH_IN) begin
          next_state    = cid_pkg::CID_ST_TEACH_A;
          next_first_in = 1'b1;
          next_teach    = 1'b1;
        end else if (new_cmd && cmd == cid_pkg::CID_CMD_TEACH_OUT) begin
          next_state    = cid_pkg::CID_ST_TEACH_A;
          next_first_in = 1'b0;
          next_teach    = 1'b1;
        end
      end
      cid_pkg::CID_ST_TEACH_A: begin
        if (reached) begin
          next_state = cid_pkg::CID_ST_TEACH_B;
        end
      end
      cid_pkg::CID_ST_TEACH_B: begin
        if (reached) begin
          next_state  = cid_pkg::CID_ST_RUN;
          next_stroke = 1'b1;
        end
      end
      default: next_state = cid_pkg::CID_ST_RUN;
    endcase
    // Powerless request aborts any run
    if (cmd == cid_pkg::CID_CMD_POWERLESS && state != cid_pkg::CID_ST_RUN) begin
      next_state  = cid_pkg::CID_ST_RUN;
      next_stroke = 1'b0;
    end
    next_ack = new_cmd && (cmd == cid_pkg::CID_CMD_POWERLESS);
    if (next_state == cid_pkg::CID_ST_RUN) begin
      next_drive_out = (cmd == cid_pkg::CID_CMD_OUT);
      next_drive_in  = (cmd == cid_pkg::CID_CMD_IN);
      next_powerless = (cmd == cid_pkg::CID_CMD_POWERLESS);
      // Undefined inputs brake rather than move
      next_hold      = ~next_drive_out & ~next_drive_in & ~next_powerless;
    end else begin
      next_slow      = 1'b1;
      next_drive_in  = next_first_in ^ (next_state == cid_pkg::CID_ST_TEACH_B);
      next_drive_out = ~next_drive_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state                   <= cid_pkg::CID_ST_RUN;
      first_in                <= 1'b0;
      mode_act                <= cid_pkg::CID_MODE_HOLD;
      cmd_q                   <= cid_pkg::CID_CMD_HOLD;
      drive_out               <= 1'b0;
      drive_in                <= 1'b0;
      slow_speed              <= 1'b0;
      hold_position           <= 1'b0;
      powerless               <= 1'b0;
      error_ack               <= 1'b0;
      teach_start             <= 1'b0;
      stroke_record           <= 1'b0;
      forbidden_combo         <= 1'b0;
      outer_endstop_indicator <= 1'b0;
      inner_endstop_indicator <= 1'b0;
    end else begin
      state                   <= next_state;
      first_in                <= next_first_in;
      mode_act                <= next_mode_act;
      cmd_q                   <= cmd;
      drive_out               <= next_drive_out;
      drive_in                <= next_drive_in;
      slow_speed              <= next_slow;
      hold_position           <= next_hold;
      powerless               <= next_powerless;
      error_ack               <= next_ack;
      teach_start             <= next_teach;
      stroke_record           <= next_stroke;
      forbidden_combo         <= next_forbid;
      outer_endstop_indicator <= at_outer_end;
      inner_endstop_indicator <= at_inner_end;
    end
  end

  // ********************************************************
  // Registers and interrupt
  // ********************************************************
  cid_regs u_regs (
    .mclk        (mclk),
    .rst         (rst),
    .address     (address),
    .read        (read),
    .write       (write),
    .writedata   (writedata),
    .readdata    (readdata),
    .waitrequest (waitrequest),
    .mode_cfg    (mode_cfg),
    .status_in   ({4'h0, inner_endstop_indicator, outer_endstop_indicator, filt,
                   cmd_q, state, mode_act}),
    .events      ({next_forbid & ~forbidden_combo, next_ack, next_stroke, next_teach}),
    .irq         (irq)
  );

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_hold_extend: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_HOLD
    && filt == 3'h1) |=> drive_out && !drive_in && !slow_speed)
    else $error("extend input did not move outward");
  a_hold_brake: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_HOLD
    && filt == 3'h0) |=> hold_position && !powerless && !drive_out)
    else $error("idle inputs did not hold position");
  a_teach_in_first: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_HOLD
    && filt == 3'h6 && cmd_q != cid_pkg::CID_CMD_TEACH_IN)
    |=> teach_start && drive_in && slow_speed ##1 !teach_start)
    else $error("teach with retract did not start inward");
  a_teach_out_first: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_HOLD
    && filt == 3'h5 && cmd_q != cid_pkg::CID_CMD_TEACH_OUT) |=> teach_start && drive_out && slow_speed)
    else $error("teach with extend did not start outward");
  a_forbid_flag: assert property ((mode_act == cid_pkg::CID_MODE_HOLD
    && filt[`CID_IN_EXT] && filt[`CID_IN_RET]) |=> forbidden_combo)
    else $error("both motion inputs not flagged");
  a_powerless_ack: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_HOLD
    && filt == 3'h4 && cmd_q != cid_pkg::CID_CMD_POWERLESS)
    |=> powerless && error_ack && !drive_out && !drive_in ##1 !error_ack)
    else $error("powerless request not acknowledged once");
  a_rest_in_motion: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_REST_IN
    && !filt[`CID_IN_TCH]) |=> drive_out == $past(filt[`CID_IN_EXT]) && drive_in != drive_out)
    else $error("rest-retracted motion wrong");
  a_rest_in_teach: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_REST_IN
    && filt[`CID_IN_TCH] && !filt[`CID_IN_EXT] && cmd_q != cid_pkg::CID_CMD_TEACH_IN)
    |=> state == cid_pkg::CID_ST_TEACH_A && drive_in)
    else $error("rest-retracted teach not inward first");
  a_rest_out_motion: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_REST_OUT
    && !filt[`CID_IN_TCH]) |=> drive_in == $past(filt[`CID_IN_RET]) && drive_in != drive_out)
    else $error("rest-extended motion wrong");
  a_rest_out_teach: assert property ((state == cid_pkg::CID_ST_RUN && mode_act == cid_pkg::CID_MODE_REST_OUT
    && filt[`CID_IN_TCH] && !filt[`CID_IN_RET] && cmd_q != cid_pkg::CID_CMD_TEACH_OUT)
    |=> state == cid_pkg::CID_ST_TEACH_A && drive_out)
    else $error("rest-extended teach not outward first");
  a_single_undef: assert property (filt[`CID_IN_TCH]
    && ((mode_act == cid_pkg::CID_MODE_REST_IN && filt[`CID_IN_EXT])
    || (mode_act == cid_pkg::CID_MODE_REST_OUT && filt[`CID_IN_RET])) |=> forbidden_combo)
    else $error("undefined single-input state not flagged");
  a_filter_stable: assert property ((in_s != cand) |=> filt == $past(filt))
    else $error("unfiltered change reached decoder");
  a_mode_static: assert property ((state != cid_pkg::CID_ST_RUN || filt != 3'h0)
    |=> mode_act == $past(mode_act))
    else $error("variant changed while active");
  a_teach_done: assert property ((state == cid_pkg::CID_ST_TEACH_B && reached
    && cmd != cid_pkg::CID_CMD_POWERLESS) |=> stroke_record && state == cid_pkg::CID_ST_RUN)
    else $error("stroke not recorded at second stop");

  c_teach_run: cover property (teach_start ##[1:200] stroke_record);
  c_powerless: cover property (error_ack);
  c_forbidden: cover property (forbidden_combo);
  c_rest_out:  cover property (mode_act == cid_pkg::CID_MODE_REST_OUT && drive_in);
endmodule

// >>> src/cid_defines.svh
// Constants of the cylinder input command decoder.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef CID_DEFINES_SVH
`define CID_DEFINES_SVH
// ********************************************************
// Timing
// ********************************************************
`define CID_CLK_MHZ      50
`define CID_FILTER_NS    1000
`define CID_FILTER_CYC   ((`CID_FILTER_NS * `CID_CLK_MHZ + 999) / 1000)
// ********************************************************
// Register map, byte addresses
// ********************************************************
`define CID_ADDR_W       4
`define CID_ADDR_CTRL    4'h0
`define CID_ADDR_STATUS  4'h4
`define CID_ADDR_IRQ_STS 4'h8
`define CID_ADDR_IRQ_MSK 4'hc
`define CID_MODE_W       2
`define CID_CTRL_RST     2'h0
// ********************************************************
// Event bits, shared by status and mask
// ********************************************************
`define CID_EV_W         4
`define CID_EV_TEACH     0
`define CID_EV_STROKE    1
`define CID_EV_ACK       2
`define CID_EV_FORBID    3
`define CID_EV_RST       4'h0
// ********************************************************
// Input vector bit positions
// ********************************************************
`define CID_IN_EXT       0
`define CID_IN_RET       1
`define CID_IN_TCH       2
`endif

// >>> src/cid_pkg.sv
// Types of the cylinder input command decoder.
// Assumes nothing of its surroundings.
package cid_pkg;
  // ********************************************************
  // Operating variants
  // ********************************************************
  typedef enum logic [1:0] {
    CID_MODE_HOLD,
    CID_MODE_REST_IN,
    CID_MODE_REST_OUT
  } cid_mode_e;
  // ********************************************************
  // Decoded commands and run states
  // ********************************************************
  typedef enum logic [2:0] {
    CID_CMD_HOLD,
    CID_CMD_OUT,
    CID_CMD_IN,
    CID_CMD_TEACH_IN,
    CID_CMD_TEACH_OUT,
    CID_CMD_POWERLESS,
    CID_CMD_UNDEF
  } cid_cmd_e;
  typedef enum logic [1:0] {
    CID_ST_RUN,
    CID_ST_TEACH_A,
    CID_ST_TEACH_B
  } cid_state_e;
endpackage

// >>> src/cid_sync.sv
// Two-flop synchroniser, one chain per bit.
// Assumes asynchronous level inputs and a single clock.
`timescale 1ns/1ps
module cid_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,  // Clock
  input  wire logic         rst,   // Sync reset
  input  wire logic [W-1:0] din,   // Asynchronous levels
  output logic      [W-1:0] dout   // Synchronised levels
);
  logic [W-1:0] stage1;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (rst) begin
          stage1[i] <= 1'b0;
          dout[i]   <= 1'b0;
        end else begin
          stage1[i] <= din[i];
          dout[i]   <= stage1[i];
        end
      end
    end
  endgenerate
endmodule

// >>> src/cid_regs.sv
// Avalon-MM register slave with sticky event status and mask.
// Assumes a master that holds its request while waitrequest is high.
`timescale 1ns/1ps
`include "cid_defines.svh"
module cid_regs (
  input  wire logic                   mclk,         // Clock
  input  wire logic                   rst,          // Sync reset
  input  wire logic [`CID_ADDR_W-1:0] address,      // Byte address
  input  wire logic                   read,         // Read request
  input  wire logic                   write,        // Write request
  input  wire logic [31:0]            writedata,    // Write data
  output logic      [31:0]            readdata,     // Read data
  output logic                        waitrequest,  // Stall
  output cid_pkg::cid_mode_e          mode_cfg,     // Configured variant
  input  wire logic [15:0]            status_in,    // Live state
  input  wire logic [`CID_EV_W-1:0]   events,       // Event pulses
  output logic                        irq           // Level interrupt
);
  logic                   done;
  logic [`CID_MODE_W-1:0] mode_q;
  logic [`CID_EV_W-1:0]   sts_q;
  logic [`CID_EV_W-1:0]   msk_q;
  logic [31:0]            next_readdata;
  logic                   next_done;
  logic [`CID_MODE_W-1:0] next_mode;
  logic [`CID_EV_W-1:0]   next_sts;
  logic [`CID_EV_W-1:0]   next_msk;
  logic                   wr_en;

  // ********************************************************
  // One wait cycle, then the access completes
  // ********************************************************
  assign waitrequest = (read | write) & ~done;
  assign wr_en       = write & done;
  assign mode_cfg    = cid_pkg::cid_mode_e'(mode_q);
  assign irq         = |(sts_q & msk_q);

  always_comb begin
    next_done     = (read | write) & ~done;
    next_readdata = readdata;
    next_mode     = mode_q;
    next_msk      = msk_q;
    next_sts      = sts_q;
    if (read & ~done) begin
      case (address)
        `CID_ADDR_CTRL:    next_readdata = {30'h0, mode_q};
        `CID_ADDR_STATUS:  next_readdata = {16'h0, status_in};
        `CID_ADDR_IRQ_STS: next_readdata = {28'h0, sts_q};
        `CID_ADDR_IRQ_MSK: next_readdata = {28'h0, msk_q};
        default:           next_readdata = 32'h0;
      endcase
    end
    if (wr_en && address == `CID_ADDR_CTRL) begin
      next_mode = writedata[`CID_MODE_W-1:0];
    end
    if (wr_en && address == `CID_ADDR_IRQ_MSK) begin
      next_msk = writedata[`CID_EV_W-1:0];
    end
    if (wr_en && address == `CID_ADDR_IRQ_STS) begin
      next_sts = sts_q & ~writedata[`CID_EV_W-1:0];
    end
    // Set wins over a clear in the same cycle
    next_sts = next_sts | events;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      done     <= 1'b0;
      readdata <= 32'h0;
      mode_q   <= `CID_CTRL_RST;
      sts_q    <= `CID_EV_RST;
      msk_q    <= `CID_EV_RST;
    end else begin
      done     <= next_done;
      readdata <= next_readdata;
      mode_q   <= next_mode;
      sts_q    <= next_sts;
      msk_q    <= next_msk;
    end
  end
endmodule

// >>> testbench/cid_ctrl_model.sv
// Machine controller and motion stand-in for the command decoder.
// Assumes drive levels on mclk; pins change only through set_pins.
`timescale 1ns/1ps
module cid_ctrl_model (
  input  wire logic mclk,       // Clock
  input  wire logic drive_out,  // Move outward
  input  wire logic drive_in,   // Move inward
  output logic      ext_pin,    // Extend pin
  output logic      ret_pin,    // Retract pin
  output logic      tch_pin,    // Teach pin
  output logic      at_outer,   // Outer stop
  output logic      at_inner    // Inner stop
);
  logic [3:0] pos = 4'h8;
  initial {ext_pin, ret_pin, tch_pin} = 3'h0;
  task automatic set_pins(input logic e, r, t, mono);
    if (!(e && r) && !(mono && t && (e || r))) begin
      @(posedge mclk);
      {ext_pin, ret_pin, tch_pin} <= {e, r, t};
    end
  endtask
  // Stroke of 15 steps, one step a cycle; unknown drive before reset moves nothing
  always @(posedge mclk)
    pos <= pos + 4'(drive_out === 1'b1 && pos != 4'hf) - 4'(drive_in === 1'b1 && pos != 4'h0);
  assign at_outer = (pos == 4'hf);
  assign at_inner = (pos == 4'h0);
endmodule

// >>> testbench/test_cylinder_input_command_decoder.sv
// Self-checking bench of the command decoder.
// Assumes cid_ctrl_model on the pin side and a bus master here.
`timescale 1ns/1ps
module test_cylinder_input_command_decoder;
  logic        mclk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
  logic [3:0]  address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic        waitrequest, irq, e, r, t, ao, ai, dout, din, slw, hld, pwl, oi, ii;
  int          error_cnt = 0, n_compared = 0;
  always #10 mclk = ~mclk;
  cid_ctrl_model ctl (.mclk(mclk), .drive_out(dout), .drive_in(din), .ext_pin(e),
    .ret_pin(r), .tch_pin(t), .at_outer(ao), .at_inner(ai));
  cid_decoder #(.FILTER_CYC(2)) uut (.mclk(mclk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .extend_request_input(e),
    .retract_request_input(r), .teach_reset_input(t), .at_outer_end(ao),
    .at_inner_end(ai), .drive_out(dout), .drive_in(din), .slow_speed(slw),
    .hold_position(hld), .powerless(pwl), .error_ack(), .teach_start(),
    .stroke_record(), .forbidden_combo(), .outer_endstop_indicator(oi),
    .inner_endstop_indicator(ii));
  task automatic chk(input logic [31:0] g, x);
    n_compared++;
    if (g !== x) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
      error_cnt++;
    end
  endtask
  task automatic finish_test;
    $display("errors=%0d compared=%0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    {write, read, address, writedata} <= {w, !w, a, d};
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (!waitrequest) break;
    end
    q = readdata;
    {write, read} <= 2'h0;
    if (k == 20) begin
      error_cnt++;
      finish_test();
    end
  endtask
  task automatic ci(input logic x);
    @(negedge mclk);
    chk(irq, x);
  endtask
  // Order of the motion vector: out, in, slow, hold, powerless
  task automatic wo(input logic [4:0] x);
    int k;
    for (k = 0; k < 40 && {dout, din, slw, hld, pwl} !== x; k++) @(posedge mclk);
    chk({dout, din, slw, hld, pwl}, x);
    if ({dout, din, slw, hld, pwl} !== x) finish_test();
  endtask
  task automatic t_hold;
    bus(1'h1, 4'h8, 32'hf);
    ctl.set_pins(1'h1, 1'h0, 1'h0, 1'h0); wo(5'h10);
    ctl.set_pins(1'h0, 1'h1, 1'h0, 1'h0); wo(5'h08);
    ctl.set_pins(1'h0, 1'h0, 1'h0, 1'h0); wo(5'h02);
    ctl.set_pins(1'h0, 1'h0, 1'h1, 1'h0); wo(5'h01);
    bus(1'h0, 4'h8, 32'h0); chk(q, 32'h4);
    ci(1'h0);
    bus(1'h1, 4'hc, 32'h4); ci(1'h1);
    bus(1'h1, 4'h8, 32'h4); ci(1'h0);
    ctl.set_pins(1'h0, 1'h0, 1'h0, 1'h0); wo(5'h02);
  endtask
  task automatic t_teach(input logic [1:0] m, input logic [2:0] p, input logic [4:0] a, b, z,
                         input logic [1:0] s);
    ctl.set_pins(1'h0, 1'h0, 1'h0, 1'h0);
    bus(1'h1, 4'h0, {30'h0, m});
    bus(1'h1, 4'h8, 32'hf);
    bus(1'h1, 4'hc, 32'h3);
    wo(z);
    bus(1'h0, 4'h4, 32'h0); chk(q[1:0], m);
    ctl.set_pins(p[2], p[1], p[0], m != 2'h0);
    wo(a);
    ctl.set_pins(1'h0, 1'h0, 1'h0, 1'h0);
    wo(b);
    wo(z);
    // Let the final motion settle on a stop, then check both indicator paths
    repeat (20) @(posedge mclk);
    bus(1'h0, 4'h4, 32'h0); chk(q[11:10], s); chk({ii, oi}, s);
    bus(1'h0, 4'h8, 32'h0); chk(q, 32'h3);
    ci(1'h1);
    bus(1'h1, 4'h8, 32'h3); ci(1'h0);
  endtask
  task automatic t_mono(input logic [2:0] p, input logic [4:0] on, off);
    ctl.set_pins(p[2], p[1], p[0], 1'h1); wo(on);
    ctl.set_pins(1'h0, 1'h0, 1'h0, 1'h1); wo(off);
  endtask
  // Reserved variant code decodes as hold-anywhere
  task automatic t_spare;
    bus(1'h1, 4'h0, 32'h3); wo(5'h02);
    ctl.set_pins(1'h0, 1'h0, 1'h1, 1'h0); wo(5'h01);
    ctl.set_pins(1'h0, 1'h0, 1'h0, 1'h0); wo(5'h02);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    t_hold();
    t_teach(2'h0, 3'h3, 5'h0c, 5'h14, 5'h02, 2'h1);
    t_teach(2'h0, 3'h5, 5'h14, 5'h0c, 5'h02, 2'h2);
    t_teach(2'h1, 3'h1, 5'h0c, 5'h14, 5'h08, 2'h2);
    t_mono(3'h4, 5'h10, 5'h08);
    t_teach(2'h2, 3'h1, 5'h14, 5'h0c, 5'h10, 2'h1);
    t_mono(3'h2, 5'h08, 5'h10);
    t_spare();
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    finish_test();
  end
endmodule
